// ==== rtl/pfp_pkg.sv ====
/*
 package of the fault-protection and configuration block: register word indices,
 field positions, reset values and bus encodings.
 assumes a 32-bit ahb-lite bus; each register sits at byte address four times its index.
*/
package pfp_pkg;

   // ==========================================================
   // register indices (byte address = index * 4)
   localparam logic [7:0] IDX_CONTROL_ONE = 8'h31;
   localparam logic [7:0] IDX_CONTROL_TWO = 8'h32;
   localparam logic [7:0] IDX_DEAD_TIME   = 8'h36;
   localparam logic [7:0] IDX_DISABLE_MAP = 8'h37;
   localparam logic [7:0] IDX_FAULT_CTRL  = 8'h38;
   localparam logic [7:0] IDX_FAULT_STAT  = 8'h39;
   localparam logic [7:0] IDX_FAULT_ACK   = 8'h3a;

   // ==========================================================
   // field positions
   localparam int CTL1_LOAD_OK  = 0;
   localparam int CTL1_SENSE_LO = 1;
   localparam int CTL1_DIS_X    = 3;
   localparam int CTL1_DIS_Y    = 4;
   localparam int CTL2_DIV_LO   = 0;
   localparam int CTL2_CORR_LO  = 2;
   localparam int CTL2_RATE_LO  = 6;
   localparam int FCTL_IRQ_LO   = 0;
   localparam int FCTL_AUTO_LO  = 4;
   localparam int FSTAT_FLAG_LO = 0;
   localparam int FSTAT_PIN_LO  = 4;
   localparam int FACK_CLR_LO   = 0;
   localparam int FACK_SENSE_LO = 4;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
   localparam logic [7:0] RST_DEAD_TIME   = 8'h00;
   localparam logic [7:0] RST_DISABLE_MAP = 8'hff;
   localparam logic [7:0] RST_FAULT_CTRL  = 8'h00;

   // ==========================================================
   // bus encodings and widths
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam int         NUM_FAULTS    = 4;
   localparam int         NUM_PAIRS     = 3;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } pfp_aphase_t;

   typedef struct packed {
      logic [1:0] reload_rate_sel;
      logic       reserved;
      logic [2:0] corr_sel;
      logic [1:0] div_sel;
   } pfp_ctl2_t;

endpackage

// ==== rtl/pfp_fault_config.sv ====
/*
 fault protection, write-once dead-time and disable map, buffered prescaler and
 correction selects, dead-time insertion for three complementary pairs.
 assumes the pwm generator on hclk supplies load-cycle and pwm-cycle pulses and one
 top-drive level per pair; fault and current-sense pins are asynchronous.
 assumes hready is tied to this slave's hreadyout; no wait states, always okay.
 assumes the address phase is decoded on its own edge, so a read right behind a
 write to the same register returns the old value.
 assumes complementary mode on every pair; independent mode is not built here.
 assumes software writes dead time and disable map once, early after reset.
 a dead time of zero still leaves a one-cycle gap between the pair outputs, as one does.
 fault and sense pins pass two flip-flops before any logic reads them, so a fault
 flag rises on the third edge after its pin and the interrupt on that same edge.
 register map, by word index; the byte address is four times the index:
    0x31 control one: load ok, sense method, bank x and bank y disables
    0x32 control two: divider select, correction selects, reload rate
    0x36 dead time count, write-once
    0x37 output disable map, write-once, resets to all ones
    0x38 fault control: interrupt enables low nibble, auto recovery high nibble
    0x39 fault status: event flags low nibble, pin levels high nibble, read-only
    0x3a fault acknowledge: clear bits low nibble, sense samples bits 9:4
 limits a user must know:
    disable map bits 7:6 are stored and read back but mask nothing
    control one is not buffered; a new sense method acts at once
    the divider copy moves only when load ok is set at a load start
    a hold released in manual mode still waits for a pwm cycle start
    a register outside the map reads zero and ignores writes
*/
`timescale 1ns/1ns
module pfp_fault_config (
   input  wire logic                            hclk,
   input  wire logic                            hresetn,
   input  wire logic                            hsel,
   input  wire logic [31:0]                     haddr,
   input  wire logic [1:0]                      htrans,
   input  wire logic                            hwrite,
   input  wire logic [2:0]                      hsize,
   input  wire logic [31:0]                     hwdata,
   input  wire logic                            hready,
   output logic                                 hreadyout,
   output logic      [31:0]                     hrdata,
   output logic                                 hresp,
   input  wire logic                            load_cycle_start,
   input  wire logic                            pwm_cycle_start,
   input  wire logic [pfp_pkg::NUM_PAIRS-1:0]   pair_top_drive,
   input  wire logic [pfp_pkg::NUM_FAULTS-1:0]  fault_pin,
   input  wire logic [pfp_pkg::NUM_PAIRS-1:0]   sense_pin_n,
   output logic      [2*pfp_pkg::NUM_PAIRS-1:0] pwm_out,
   output logic                                 counter_tick,
   output logic      [pfp_pkg::NUM_PAIRS-1:0]   use_even_value,
   output logic      [1:0]                      reload_rate_work,
   output logic                                 fault_irq
);
   import pfp_pkg::*;

   // ==========================================================
   // register state
   // every flop below runs on hclk and takes its reset value on hresetn

   // two-stage pin synchronisers and the edge memory behind them
   logic [NUM_FAULTS-1:0]  fault_sync1;
   logic [NUM_FAULTS-1:0]  fault_sync2;
   logic [NUM_FAULTS-1:0]  fault_prev;
   logic [NUM_PAIRS-1:0]   sense_sync1;
   logic [NUM_PAIRS-1:0]   sense_sync2;

   // address phase held over into the data phase
   pfp_aphase_t            aphase;

   // control one fields, unbuffered
   logic                   load_ok_bit;
   logic [1:0]             sense_method;
   logic                   dis_bank_x;
   logic                   dis_bank_y;

   // control two buffer as software sees it, and the copies in use
   pfp_ctl2_t              ctl2_buf;
   logic [1:0]             div_work;
   logic [2:0]             div_count;
   logic [2:0]             corr_work;

   // write-once registers and their lock bits
   logic [7:0]             dead_time_count;
   logic                   dead_time_locked;
   logic [7:0]             fault_output_disable_map;
   logic                   map_locked;

   // fault control, event flags and output hold
   logic [3:0]             fault_irq_enable;
   logic [3:0]             fault_auto_recovery;
   logic [3:0]             fault_event_flag;
   logic [3:0]             fault_hold;

   // dead-time engine and current-sense samples
   // one down-counter per pair, loaded on every toggle
   logic [5:0]             sense_sample;
   logic [NUM_PAIRS-1:0]   pair_prev;
   logic [7:0]             dt_cnt [NUM_PAIRS];
   // sample bit 2p is the top channel of pair p

   // ==========================================================
   // bus decode
   // one slave, one wait-free data phase per taken transfer

   function automatic logic is_reg(input logic [7:0] idx, input logic [7:0] want);
      is_reg = (idx == want);
   endfunction

   // only aligned word transfers inside the 1 kbyte window are taken
   wire        take     = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD)
                          & (haddr[1:0] == 2'h0) & (haddr[31:10] == 22'h0);
   wire [7:0]  a_idx    = haddr[9:2];
   wire        wr_act   = aphase.valid & aphase.write;
   wire [7:0]  wd       = hwdata[7:0];
   wire        wr_ctl1  = wr_act & is_reg(aphase.index, IDX_CONTROL_ONE);
   wire        wr_ctl2  = wr_act & is_reg(aphase.index, IDX_CONTROL_TWO);
   wire        wr_dt    = wr_act & is_reg(aphase.index, IDX_DEAD_TIME);
   wire        wr_map   = wr_act & is_reg(aphase.index, IDX_DISABLE_MAP);
   wire        wr_fctl  = wr_act & is_reg(aphase.index, IDX_FAULT_CTRL);
   wire        wr_ack   = wr_act & is_reg(aphase.index, IDX_FAULT_ACK);
   // fault status gets no write strobe at all
   // acknowledge zeros leave the flags alone
   wire [3:0]  ack_bits = wr_ack ? wd[FACK_CLR_LO +: 4] : 4'h0;

   // ==========================================================
   // fault edge, recovery, outputs disable
   // hold follows the synchronised pin, never the raw one

   // a new rising edge outranks an acknowledge in the same cycle
   wire [3:0]  fault_rise   = fault_sync2 & ~fault_prev;
   wire [3:0]  next_flag    = fault_rise | (fault_event_flag & ~ack_bits);
   // release needs the pin low, and in manual mode a cleared flag too
   wire [3:0]  may_recover  = ~fault_sync2 & (fault_auto_recovery | ~next_flag);
   wire [3:0]  next_hold    = fault_sync2
                              | (fault_hold & ~(may_recover & {4{pwm_cycle_start}}));
   // mapped outputs stay masked while any hold bit is set
   wire        any_fault    = |fault_hold;
   // bank x covers channels 1-4, bank y channels 5-6
   wire [5:0]  bank_disable = {{2{dis_bank_y}}, {4{dis_bank_x}}};
   wire [5:0]  out_disable  = fault_output_disable_map[5:0]
                              & ({6{any_fault}} | bank_disable);

   // ==========================================================
   // read data mux
   // read data comes from the buffers, never from the working copies

   wire [31:0] rd_ctl1 = {27'h0, dis_bank_y, dis_bank_x, sense_method, load_ok_bit};
   wire [31:0] rd_fst  = {24'h0, fault_sync2, fault_event_flag};
   // acknowledge bits always read zero
   wire [31:0] rd_ack  = {22'h0, sense_sample, 4'h0};
   wire [31:0] rd_mux  = is_reg(a_idx, IDX_CONTROL_ONE) ? rd_ctl1 :
                         is_reg(a_idx, IDX_CONTROL_TWO) ? {24'h0, ctl2_buf} :
                         is_reg(a_idx, IDX_DEAD_TIME)   ? {24'h0, dead_time_count} :
                         is_reg(a_idx, IDX_DISABLE_MAP) ? {24'h0, fault_output_disable_map} :
                         is_reg(a_idx, IDX_FAULT_CTRL)  ?
                            {24'h0, fault_auto_recovery, fault_irq_enable} :
                         is_reg(a_idx, IDX_FAULT_STAT)  ? rd_fst :
                         is_reg(a_idx, IDX_FAULT_ACK)   ? rd_ack : 32'h0;

   // ==========================================================
   // prescaler tick
   // counts hclk only; dead-time never looks at it

   // wrap at 2**code - 1, so a tick every 1, 2, 4 or 8 cycles
   wire [2:0]  div_last   = (3'h1 << div_work) - 3'h1;
   wire        div_wrap   = (div_count >= div_last);
   // software correction only for sense methods 00 and 01
   wire        corr_valid = ~sense_method[1];

   // ==========================================================
   // ahb slave
   // read data latched at the address phase, cleared otherwise

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aphase    <= '0;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         // zero wait states, so every ready edge closes an address phase
         if (hready) begin
            aphase.valid <= take;
            aphase.write <= hwrite;
            aphase.index <= a_idx;
            hrdata       <= (take & ~hwrite) ? rd_mux : 32'h0;
         end
      end
   end

   // ==========================================================
   // pin synchronisers
   // two stages per asynchronous pin

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_sync1 <= 4'h0;
         fault_sync2 <= 4'h0;
         fault_prev  <= 4'h0;
         sense_sync1 <= 3'h0;
         sense_sync2 <= 3'h0;
      end else begin
         // only the second stage feeds logic
         fault_sync1 <= fault_pin;
         fault_sync2 <= fault_sync1;
         fault_prev  <= fault_sync2;
         sense_sync1 <= sense_pin_n;
         sense_sync2 <= sense_sync1;
      end
   end

   // ==========================================================
   // control registers
   // control one direct, control two through its buffer

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_ok_bit  <= 1'b0;
         sense_method <= 2'h0;
         dis_bank_x   <= 1'b0;
         dis_bank_y   <= 1'b0;
         ctl2_buf     <= RST_CONTROL_TWO;
         div_work     <= 2'h0;
         corr_work    <= 3'h0;
      end else begin
         // a write in the load cycle wins over the hardware clear
         if (wr_ctl1) begin
            load_ok_bit  <= wd[CTL1_LOAD_OK];
            sense_method <= wd[CTL1_SENSE_LO +: 2];
            dis_bank_x   <= wd[CTL1_DIS_X];
            dis_bank_y   <= wd[CTL1_DIS_Y];
         end else if (load_cycle_start) begin
            load_ok_bit <= 1'b0;
         end
         if (wr_ctl2) begin
            ctl2_buf <= wd & 8'hdf;
         end
         // selects follow every load start, the divider only with load ok
         if (load_cycle_start) begin
            corr_work <= ctl2_buf.corr_sel;
            if (load_ok_bit) begin
               div_work <= ctl2_buf.div_sel;
            end
         end
      end
   end

   // ==========================================================
   // write-once registers and fault control
   // fault control stays writable at any time

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dead_time_count          <= RST_DEAD_TIME;
         dead_time_locked         <= 1'b0;
         fault_output_disable_map <= RST_DISABLE_MAP;
         map_locked               <= 1'b0;
         fault_irq_enable         <= RST_FAULT_CTRL[FCTL_IRQ_LO +: 4];
         fault_auto_recovery      <= RST_FAULT_CTRL[FCTL_AUTO_LO +: 4];
      end else begin
         // the lock bit turns every later write into a no-op
         if (wr_dt && !dead_time_locked) begin
            dead_time_count  <= wd;
            dead_time_locked <= 1'b1;
         end
         if (wr_map && !map_locked) begin
            fault_output_disable_map <= wd;
            map_locked               <= 1'b1;
         end
         if (wr_fctl) begin
            fault_irq_enable    <= wd[FCTL_IRQ_LO +: 4];
            fault_auto_recovery <= wd[FCTL_AUTO_LO +: 4];
         end
      end
   end

   // ==========================================================
   // fault flags, hold and interrupt
   // protection acts whatever the interrupt enables say

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_event_flag <= 4'h0;
         fault_hold       <= 4'h0;
         fault_irq        <= 1'b0;
      end else begin
         // interrupt rises on the same edge as the flags, gated per input
         fault_event_flag <= next_flag;
         fault_hold       <= next_hold;
         fault_irq        <= |(next_flag & fault_irq_enable);
      end
   end

   // ==========================================================
   // prescaler and working outputs
   // working copies handed to the generator

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_count        <= 3'h0;
         counter_tick     <= 1'b0;
         use_even_value   <= 3'h0;
         reload_rate_work <= 2'h0;
      end else begin
         // a shorter divide after a load wraps at once
         div_count    <= div_wrap ? 3'h0 : div_count + 3'h1;
         counter_tick <= div_wrap;
         use_even_value <= corr_valid ? corr_work : 3'h0;
         if (load_cycle_start) begin
            reload_rate_work <= ctl2_buf.reload_rate_sel;
         end
      end
   end

   // ==========================================================
   // dead-time insertion and current-sense capture
   // both outputs of a pair stay off for the gap

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pair_prev    <= 3'h0;
         sense_sample <= 6'h0;
         pwm_out      <= 6'h0;
         for (int p = 0; p < NUM_PAIRS; p++) begin
            dt_cnt[p] <= 8'h0;
         end
      end else begin
         // any toggle restarts the gap of its pair
         pair_prev <= pair_top_drive;
         for (int p = 0; p < NUM_PAIRS; p++) begin
            if (pair_top_drive[p] != pair_prev[p]) begin
               dt_cnt[p] <= dead_time_count;
            end else if (dt_cnt[p] != 8'h0) begin
               dt_cnt[p] <= dt_cnt[p] - 8'h1;
            end
            // sample on the last gap cycle into the channel being asserted
            if (dt_cnt[p] == 8'h1 && pair_top_drive[p] == pair_prev[p]) begin
               sense_sample[2*p + (pair_top_drive[p] ? 0 : 1)] <= sense_sync2[p];
            end
            // mapped outputs forced inactive on fault or bank disable
            if (dt_cnt[p] > 8'h1 || pair_top_drive[p] != pair_prev[p]) begin
               pwm_out[2*p +: 2] <= 2'h0;
            end else begin
               pwm_out[2*p]     <= pair_top_drive[p] & ~out_disable[2*p];
               pwm_out[2*p + 1] <= ~pair_top_drive[p] & ~out_disable[2*p + 1];
            end
         end
      end
   end

endmodule

// ==== test/pfp_fault_config_checker.sv ====
/*
 checker on the block's ports: bus answer, read data, dead-time gaps.
 assumes it is bound to pfp_fault_config.
*/
`timescale 1ns/1ns
module pfp_fault_config_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        load_cycle_start,
   input wire logic [2:0]  pair_top_drive,
   input wire logic [3:0]  fault_pin,
   input wire logic [5:0]  pwm_out,
   input wire logic [1:0]  reload_rate_work
);
   import pfp_pkg::*;
   // ==========================================
   // read address phase
   wire       rd_ap = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && hsize == HSIZE_WORD;
   wire [7:0] idx   = haddr[9:2];
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   chk_rdata_idle: assert property (!rd_ap |=> hrdata == 32'h0)
      else $error("read data not cleared");
   chk_ack_zero: assert property (rd_ap && idx == IDX_FAULT_ACK |=> hrdata[3:0] == 4'h0)
      else $error("acknowledge bits read nonzero");
   chk_ctl2_bits: assert property (rd_ap && idx == IDX_CONTROL_TWO |=> !hrdata[5])
      else $error("control two reserved bit set");
   chk_status_pin: assert property (($stable(fault_pin) [*4] ##0 rd_ap && idx == IDX_FAULT_STAT)
      |=> hrdata[7:4] == $past(fault_pin))
      else $error("fault pin level wrong");
   chk_pair_apart: assert property (!(pwm_out[0] && pwm_out[1]) && !(pwm_out[2] && pwm_out[3])
      && !(pwm_out[4] && pwm_out[5]))
      else $error("pair outputs both active");
   chk_top_rise: assert property ($rose(pair_top_drive[0]) |=> !pwm_out[1])
      else $error("bottom not off after top request");
   chk_top_fall: assert property ($fell(pair_top_drive[0]) |=> !pwm_out[0])
      else $error("top not off after bottom request");
   chk_rate_hold: assert property (!load_cycle_start |=> $stable(reload_rate_work))
      else $error("reload rate moved outside load");
endmodule

// ==== test/pfp_power_stage.sv ====
/*
 power stage model: fault sensors, current sense comparators, shoot-through monitor.
 assumes the bench commands pin levels; pins move off the clock edge.
*/
`timescale 1ns/1ns
module pfp_power_stage (
   input  wire logic [0:0] hclk,
   input  wire logic [5:0] pwm_out,
   input  wire logic [3:0] fault_req,
   input  wire logic [2:0] sense_req,
   output logic      [3:0] fault_pin,
   output logic      [2:0] sense_pin_n,
   output int              shoot_through
);
   // ==========================================
   // pins settle 3 ns after the edge
   initial begin
      fault_pin = 4'h0;
      sense_pin_n = 3'h0;
      shoot_through = 0;
   end
   always @(posedge hclk) begin
      fault_pin <= #3 fault_req;
      sense_pin_n <= #3 sense_req;
      if ((pwm_out[0] && pwm_out[1]) || (pwm_out[2] && pwm_out[3]) || (pwm_out[4] && pwm_out[5]))
         shoot_through <= shoot_through + 1;
   end
endmodule

// ==== test/pfp_fault_config_tb.sv ====
/*
 self-checking bench: register model, bus master, divider, dead-time and fault tests.
 assumes pfp_pkg and the power stage model.
*/
`timescale 1ns/1ns
module pfp_fault_config_tb;
   import pfp_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, load_cycle_start = 0, pwm_cycle_start = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0, reload_rate_work;
   logic [2:0] hsize = HSIZE_WORD, pair_top_drive = 0, sense_req = 0, use_even_value, sense_pin_n;
   logic [3:0] fault_req = 0, fault_pin;
   logic [5:0] pwm_out;
   logic hreadyout, hresp, counter_tick, fault_irq;
   int n_errors = 0, tests_run = 0, shoot, g, i;
   int m_dt, m_map = 'hff, m_ctl2, m_fctl, m_flag, m_pin;
   bit dt_done, map_done;
   logic [7:0] ids [7] = '{IDX_CONTROL_TWO, IDX_DEAD_TIME, IDX_DISABLE_MAP, IDX_FAULT_CTRL,
      IDX_FAULT_STAT, IDX_FAULT_ACK, 8'h30};
   always #5 hclk = ~hclk;
   always @(posedge hclk) pwm_cycle_start <= ($urandom % 16) == 0;
   pfp_fault_config pfp_fault_config_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .load_cycle_start(load_cycle_start), .pwm_cycle_start(pwm_cycle_start),
      .pair_top_drive(pair_top_drive), .fault_pin(fault_pin), .sense_pin_n(sense_pin_n),
      .pwm_out(pwm_out), .counter_tick(counter_tick), .use_even_value(use_even_value),
      .reload_rate_work(reload_rate_work), .fault_irq(fault_irq));
   pfp_power_stage pfp_power_stage_inst (.hclk(hclk), .pwm_out(pwm_out), .fault_req(fault_req),
      .sense_req(sense_req), .fault_pin(fault_pin), .sense_pin_n(sense_pin_n), .shoot_through(shoot));
   // ==========================================
   // checking, bus and model tasks
   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task print_verdict;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wait_rdy;
      int k;
      k = 0;
      do begin
         @(negedge hclk);
         rd = hrdata;
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         $display("[ERR] %0t bus hang", $time);
         print_verdict();
      end
      @(posedge hclk);
   endtask
   task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d);
      case (idx)
         IDX_CONTROL_TWO: m_ctl2 = d & 8'hdf;
         IDX_FAULT_CTRL: m_fctl = d;
         IDX_FAULT_ACK: m_flag &= ~int'(d);
         IDX_DEAD_TIME: if (!dt_done) begin
            m_dt = d;
            dt_done = 1;
         end
         IDX_DISABLE_MAP: if (!map_done) begin
            m_map = d;
            map_done = 1;
         end
         default: ;
      endcase
      bus(1'b1, idx, {24'h0, d});
   endtask
   function logic [31:0] mr(input logic [7:0] idx);
      case (idx)
         IDX_CONTROL_TWO: return m_ctl2;
         IDX_DEAD_TIME: return m_dt;
         IDX_DISABLE_MAP: return m_map;
         IDX_FAULT_CTRL: return m_fctl;
         IDX_FAULT_STAT: return m_pin * 16 + m_flag;
         default: return 0;
      endcase
   endfunction
   task rc(input logic [7:0] idx);
      bus(1'b0, idx, 32'h0);
      check(idx == IDX_FAULT_ACK ? rd & 32'hf : rd, mr(idx), $sformatf("read %h", idx));
   endtask
   task pulse_load;
      load_cycle_start <= 1'b1;
      @(posedge hclk);
      load_cycle_start <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask
   task tick_gap;
      int f;
      f = -1;
      g = 0;
      for (int k = 0; k < 40 && g == 0; k++) begin
         @(negedge hclk);
         if (counter_tick === 1'b1 && f >= 0) g = k - f;
         if (counter_tick === 1'b1) f = k;
      end
      @(posedge hclk);
   endtask
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(44));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ids[k]) rc(ids[k]);
      wr(IDX_DEAD_TIME, 8'(1 + $urandom % 8));
      wr(IDX_DISABLE_MAP, 8'($urandom) | 8'h02);
      wr(IDX_CONTROL_TWO, 8'($urandom));
      wr(IDX_DEAD_TIME, 8'h00);
      wr(IDX_DISABLE_MAP, 8'h00);
      wr(IDX_FAULT_STAT, 8'hff);
      wr(IDX_FAULT_ACK, 8'h00);
      foreach (ids[k]) rc(ids[k]);
      pulse_load();
      check(use_even_value, m_ctl2 >> 2 & 7, "correction select");
      check(reload_rate_work, m_ctl2 >> 6, "reload rate");
      i = m_ctl2;
      wr(IDX_CONTROL_TWO, 8'(~i));
      rc(IDX_CONTROL_TWO);
      check(use_even_value, i >> 2 & 7, "select held");
      for (i = 0; i < 4; i++) begin
         wr(IDX_CONTROL_TWO, 8'(i));
         wr(IDX_CONTROL_ONE, 8'h01);
         pulse_load();
         tick_gap();
         tick_gap();
         check(g, 1 << i, "divider gap");
      end
      sense_req <= 3'($urandom);
      repeat (4) @(posedge hclk);
      pair_top_drive <= 3'h1;
      g = 0;
      for (i = 0; i < 300 && pwm_out[0] !== 1'b1; i++) begin
         @(negedge hclk);
         if (pwm_out[1:0] === 2'b00) g++;
      end
      @(posedge hclk);
      check(g, m_dt, "dead-time length");
      bus(1'b0, IDX_FAULT_ACK, 32'h0);
      check(rd[4], sense_req[0], "sense sample");
      pair_top_drive <= 3'h0;
      wr(IDX_FAULT_CTRL, 8'h01);
      fault_req <= 4'h3;
      m_pin = 3;
      m_flag = 3;
      repeat (8) @(posedge hclk);
      rc(IDX_FAULT_STAT);
      check(fault_irq, 1, "irq raised");
      check(pwm_out & 6'(m_map), 0, "mapped outputs off");
      wr(IDX_FAULT_ACK, 8'h01);
      rc(IDX_FAULT_STAT);
      rc(IDX_FAULT_ACK);
      check(fault_irq, 0, "irq gated");
      fault_req <= 4'h0;
      m_pin = 0;
      repeat (8) @(posedge hclk);
      wr(IDX_FAULT_ACK, 8'h02);
      rc(IDX_FAULT_STAT);
      repeat (100) @(posedge hclk);
      check(pwm_out[1], 1'b1, "outputs resume");
      check(shoot, 0, "shoot-through");
      print_verdict();
   end
endmodule
bind pfp_fault_config pfp_fault_config_checker chk_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .load_cycle_start(load_cycle_start),
   .pair_top_drive(pair_top_drive), .fault_pin(fault_pin), .pwm_out(pwm_out),
   .reload_rate_work(reload_rate_work));
